/* rtl/timer_counter_16bit_buffered.sv */
`timescale 1ns/10ps
// 16-bit timer/counter with byte register access
module timer_counter_16bit_buffered (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        ext_clock_pin_i,
  input  wire logic        osc_clk_i,
  input  wire logic        secondary_osc_enable_i,
  input  wire logic [4:0]  special_event_i,
  input  wire logic [19:0] compare_mode_field_i,
  input  wire logic [1:0]  port_direction_i,
  input  wire logic [1:0]  port_out_i,
  input  wire logic [1:0]  pin_in_i,
  output logic      [1:0]  pin_out_o,
  output logic      [1:0]  pin_oe_o,
  output logic      [1:0]  pin_read_o,
  output logic      [4:0]  timebase_route_o,
  output logic             irq_o
);
  // all state of the core
  typedef struct packed {
    logic [7:0]  ctrl;      // timer_control
    logic [15:0] count;     // live counter
    logic [7:0]  hbuf;      // high byte buffer
    logic        flag;      // overflow_flag
    logic        irq_en;    // overflow_irq_enable
    logic [1:0]  div;       // instruction clock divider
    logic [2:0]  presc;     // prescaler counter
    logic [7:0]  rdata;     // read answer
    logic        irq;       // interrupt line
    logic [4:0]  route;     // unit time-base routing
    logic [1:0]  pin_s1;    // pin sync first stage
    logic [1:0]  pin_s2;    // pin sync second stage
    logic [1:0]  pin_oe;    // pin drive enables
    logic [1:0]  pin_read;  // pin values seen by software
    logic [1:0]  pin_out;   // pin drive values
  } state_type;

  state_type                 q, d;
  timer_pkg::clock_mode_type mode;       // active counting mode
  logic                      inst_tick;  // one instruction cycle
  logic                      src_event;  // chosen source event
  logic                      tick;       // prescaled count event
  logic                      sev_rst;    // special-event clear
  logic                      wr_low;     // low byte write
  logic                      wr_high;    // high byte write
  logic                      wr_cnt;     // any counter write
  logic                      wide;       // wide access mode
  logic                      wrap;       // counter wraps now
  logic [4:0]                unit_sev;   // triggering units
  logic                      ext_src;    // raw external clock

  edge_if edge_bus ();

  // external source: oscillator when enabled, else the pin
  assign ext_src            = secondary_osc_enable_i ? osc_clk_i : ext_clock_pin_i;
  assign edge_bus.bypass    = q.ctrl[timer_pkg::BIT_SYNC_BYPASS];
  assign edge_bus.arm_clear = wr_low | ~q.ctrl[timer_pkg::BIT_COUNTER_RUN];

  ext_edge_detect u_edge (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .ext_clk_i (ext_src),
    .bus       (edge_bus)
  );

  // next state of the core
  always_comb begin
    d         = q;
    wide      = q.ctrl[timer_pkg::BIT_WIDE_ACCESS];
    mode      = timer_pkg::clock_mode(q.ctrl);
    wr_low    = wr_i && (addr_i == timer_pkg::ADDR_COUNT_LOW);
    wr_high   = wr_i && (addr_i == timer_pkg::ADDR_COUNT_HIGH);
    wr_cnt    = wr_low || (wr_high && !wide);
    tick      = 1'b0;
    wrap      = 1'b0;
    // instruction clock is a quarter of the core clock
    d.div     = q.div + 2'h1;
    inst_tick = (q.div == timer_pkg::INST_DIV_LAST);
    // bypass bit only matters for the external source
    if (mode == timer_pkg::MODE_TIMER) begin
      src_event = inst_tick;
    end else begin
      src_event = edge_bus.rise;
    end
    // unit triggers in special-event compare mode
    for (int i = 0; i < int'(timer_pkg::UNITS); i++) begin
      unit_sev[i] = special_event_i[i] && (compare_mode_field_i[i*4 +: 4] == timer_pkg::SPECIAL_EVENT_CMP);
    end
    // clear only for units routed here, not in unsynced mode
    sev_rst = |(unit_sev & q.route) && (mode != timer_pkg::MODE_ASYNC);
    // prescaler runs only while counting
    if (q.ctrl[timer_pkg::BIT_COUNTER_RUN] && src_event) begin
      if (q.presc == timer_pkg::prescale_last(q.ctrl[5:4])) begin
        d.presc = 3'h0;
        tick    = 1'b1;
      end else begin
        d.presc = q.presc + 3'h1;
      end
    end
    // low byte write restarts the prescaler
    if (wr_low) begin
      d.presc = 3'h0;
    end
    // counter: write first, then special clear, then count
    if (wr_low) begin
      if (wide) begin
        d.count = {q.hbuf, wdata_i};
      end else begin
        d.count[7:0] = wdata_i;
      end
    end else if (wr_high && !wide) begin
      d.count[15:8] = wdata_i;
    end else if (sev_rst) begin
      d.count = 16'h0000;
    end else if (tick) begin
      d.count = q.count + 16'h0001;
      wrap    = (q.count == timer_pkg::COUNT_MAX);
    end
    // high writes in wide mode only touch the buffer
    if (wr_high && wide) begin
      d.hbuf = wdata_i;
    end
    // control register
    if (wr_i && addr_i == timer_pkg::ADDR_CONTROL) begin
      d.ctrl = wdata_i;
    end
    // flag and enable; a wrap beats a clear
    if (wr_i && addr_i == timer_pkg::ADDR_IRQ) begin
      d.flag   = wdata_i[timer_pkg::BIT_OVERFLOW_FLAG];
      d.irq_en = wdata_i[timer_pkg::BIT_OVERFLOW_IE];
    end
    if (wrap) begin
      d.flag = 1'b1;
    end
    // line follows the new flag, so a clear drops it at once
    d.irq   = d.flag & d.irq_en;
    // routing settles one cycle after a control write
    d.route = timer_pkg::route_mask({q.ctrl[timer_pkg::BIT_ROUTE_HI], q.ctrl[timer_pkg::BIT_ROUTE_LO]});
    // read answer stands one cycle only
    d.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        timer_pkg::ADDR_CONTROL: begin
          d.rdata = q.ctrl;
        end
        timer_pkg::ADDR_COUNT_LOW: begin
          d.rdata = q.count[7:0];
          if (wide) begin
            d.hbuf = q.count[15:8];
          end
        end
        timer_pkg::ADDR_COUNT_HIGH: begin
          d.rdata = wide ? q.hbuf : q.count[15:8];
        end
        timer_pkg::ADDR_IRQ: begin
          d.rdata = {6'h00, q.irq_en, q.flag};
        end
        default: begin
          d.rdata = 8'h00;  // unmapped reads zero
        end
      endcase
    end
    // oscillator pins: inputs, read as zero
    d.pin_s1  = pin_in_i;
    d.pin_s2  = q.pin_s1;
    d.pin_out = port_out_i;
    if (secondary_osc_enable_i) begin
      d.pin_oe   = 2'h0;
      d.pin_read = 2'h0;
    end else begin
      d.pin_oe   = ~port_direction_i;
      d.pin_read = q.pin_s2;
    end
  end

  // register the core; reset clears control
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q      <= '0;
      q.ctrl <= timer_pkg::CONTROL_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o          = q.rdata;
  assign irq_o            = q.irq;
  assign timebase_route_o = q.route;
  assign pin_oe_o         = q.pin_oe;
  assign pin_read_o       = q.pin_read;
  assign pin_out_o        = q.pin_out;

  // counter holds while stopped and untouched
  chk_stop_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    (!q.ctrl[0] && !wr_cnt && !sev_rst) |=> $stable(q.count)) else $error("counter moved while stopped");

  // wrap from max gives zero and the flag
  chk_wrap_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (tick && q.count == 16'hFFFF && !wr_cnt && !sev_rst) |=> (q.count == 16'h0000 && q.flag))
    else $error("wrap did not clear counter and set flag");

  // special clear leaves the flag alone
  chk_sev_no_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (sev_rst && !wr_cnt && !q.flag && !wr_i) |=> (q.count == 16'h0000 && !q.flag))
    else $error("special clear misbehaved");

  // write beats a coincident special clear
  chk_write_wins: assert property (@(posedge clk_i) disable iff (reset_i)
    (sev_rst && wr_low && !wide) |=> q.count[7:0] == $past(wdata_i)) else $error("special clear beat a write");

  // low read latches the high byte
  chk_low_read_latch: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_i && addr_i == 4'h1 && wide) |=> (q.hbuf == $past(q.count[15:8]) && q.rdata == $past(q.count[7:0])))
    else $error("low read did not latch high byte");

  // wide low write loads both bytes at once
  chk_wide_write: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_high && wide) ##1 (wr_low && wide) |=> q.count == {$past(wdata_i, 2), $past(wdata_i)})
    else $error("wide write did not load 16 bits");

  // low write restarts the prescaler
  chk_presc_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_low |=> q.presc == 3'h0) else $error("prescaler not cleared");

  // internal source gives one event per four clocks
  chk_inst_rate: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode == timer_pkg::MODE_TIMER && src_event) |=> !src_event [*3]) else $error("instruction rate wrong");

  // oscillator pins undriven and read zero
  chk_osc_pins: assert property (@(posedge clk_i) disable iff (reset_i)
    secondary_osc_enable_i |=> (pin_oe_o == 2'h0 && pin_read_o == 2'h0)) else $error("oscillator pins not inputs");

  // reset leaves the control register clear
  chk_reset_ctrl: assert property (@(posedge clk_i)
    reset_i |=> q.ctrl == 8'h00) else $error("control not cleared by reset");

  // read data stand one cycle and fall back to zero
  chk_rdata_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data stood without a read");

  // narrow low write changes only the low byte
  chk_narrow_low: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_low && !wide) |=> q.count == {$past(q.count[15:8]), $past(wdata_i)})
    else $error("narrow low write disturbed the high byte");

  // narrow high write reaches the live byte
  chk_narrow_high: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_high && !wide) |=> q.count[15:8] == $past(wdata_i))
    else $error("narrow high write lost");

  // wide high write fills the buffer
  chk_wide_high_buf: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_high && wide) |=> q.hbuf == $past(wdata_i))
    else $error("wide high write missed the buffer");

  // wide high read answers from the buffer
  chk_wide_high_read: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd_i && addr_i == timer_pkg::ADDR_COUNT_HIGH && wide) |=> rdata_o == $past(q.hbuf))
    else $error("wide high read bypassed the buffer");

  // high write leaves the prescaler alone
  chk_high_keeps_presc: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_high && !(q.ctrl[timer_pkg::BIT_COUNTER_RUN] && src_event)) |=> $stable(q.presc))
    else $error("high write moved the prescaler");

  // prescaler frozen while stopped
  chk_presc_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (!q.ctrl[timer_pkg::BIT_COUNTER_RUN] && !wr_low) |=> $stable(q.presc))
    else $error("prescaler moved while stopped");

  // enable off keeps the interrupt line low
  chk_irq_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    (!q.irq_en && !(wr_i && addr_i == timer_pkg::ADDR_IRQ)) |=> !irq_o)
    else $error("interrupt raised while disabled");

  // route code 11 hands every unit to this pair
  chk_route_all: assert property (@(posedge clk_i) disable iff (reset_i)
    (q.ctrl[timer_pkg::BIT_ROUTE_HI] && q.ctrl[timer_pkg::BIT_ROUTE_LO]) |=> timebase_route_o == 5'h1F)
    else $error("route code 11 not applied");

  // route code 00 hands no unit to this pair
  chk_route_none: assert property (@(posedge clk_i) disable iff (reset_i)
    !(q.ctrl[timer_pkg::BIT_ROUTE_HI] || q.ctrl[timer_pkg::BIT_ROUTE_LO]) |=> timebase_route_o == 5'h00)
    else $error("route code 00 not applied");

  // pins follow their direction bits while the oscillator is off
  chk_pin_dir: assert property (@(posedge clk_i) disable iff (reset_i)
    !secondary_osc_enable_i |=> pin_oe_o == ~$past(port_direction_i))
    else $error("pin enables ignore direction bits");

  // main scenarios
  cov_wrap:       cover property (@(posedge clk_i) disable iff (reset_i) wrap);
  cov_sev_clear:  cover property (@(posedge clk_i) disable iff (reset_i) sev_rst && !wr_cnt);
  cov_wide_read:  cover property (@(posedge clk_i) disable iff (reset_i) rd_i && wide && addr_i == 4'h1);
  cov_ext_count:  cover property (@(posedge clk_i) disable iff (reset_i) tick && mode == timer_pkg::MODE_SYNC);
  cov_sev_write:  cover property (@(posedge clk_i) disable iff (reset_i) sev_rst && wr_low);
endmodule // timer_counter_16bit_buffered

/* rtl/timer_pkg.sv */
// How it works
// - 16-bit up-counter behind two byte registers
// - three modes: timer, synced, unsynced counter
// - internal source counts once per four clocks
// - external rising edges count after first fall
// - bypass bit chooses synced or unsynced counting
// - bypass bit ignored while internal source chosen
// - prescale by 1, 2, 4 or 8
// - counts only while run bit set
// - route field assigns units to timer pairs
// - oscillator on: pins inputs, read zero
// - control bit 7 selects wide buffered access
// - wide mode: high address hits buffer
// - wide mode: low read latches high byte
// - wide mode: high byte loads on low write
// - wide mode: live high byte not reachable
// - low write clears prescaler, high does not
// - wrap sets sticky flag, enable gates interrupt
// - special-event compare trigger from a unit routed here clears counter, except in unsynced mode
// - software write beats special-event clear
// - special-event clear never sets flag
package timer_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned UNITS  = 5;
  // register addresses
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW  = 4'h1;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_IRQ        = 4'h3;
  // control field positions
  localparam int unsigned BIT_COUNTER_RUN   = 0;
  localparam int unsigned BIT_CLOCK_SOURCE  = 1;
  localparam int unsigned BIT_SYNC_BYPASS   = 2;
  localparam int unsigned BIT_ROUTE_LO      = 3;
  localparam int unsigned BIT_PRESCALE_LO   = 4;
  localparam int unsigned BIT_PRESCALE_HI   = 5;
  localparam int unsigned BIT_ROUTE_HI      = 6;
  localparam int unsigned BIT_WIDE_ACCESS   = 7;
  // irq register field positions
  localparam int unsigned BIT_OVERFLOW_FLAG = 0;
  localparam int unsigned BIT_OVERFLOW_IE   = 1;
  // reset values and constants
  localparam logic [7:0]  CONTROL_RESET     = 8'h00;
  localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
  localparam logic [1:0]  INST_DIV_LAST     = 2'h3;
  localparam logic [3:0]  SPECIAL_EVENT_CMP = 4'hB;

  // counting modes
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_SYNC  = 2'b01,
    MODE_ASYNC = 2'b10
  } clock_mode_type;

  // mode from source select and bypass bit
  function automatic clock_mode_type clock_mode(input logic [7:0] ctrl);
    if (!ctrl[BIT_CLOCK_SOURCE]) return MODE_TIMER;
    return ctrl[BIT_SYNC_BYPASS] ? MODE_ASYNC : MODE_SYNC;
  endfunction

  // last prescaler count for a select code
  function automatic logic [2:0] prescale_last(input logic [1:0] sel);
    case (sel)
      2'h0:    return 3'h0;
      2'h1:    return 3'h1;
      2'h2:    return 3'h3;
      default: return 3'h7;
    endcase
  endfunction

  // units that take their time base from this timer pair
  function automatic logic [4:0] route_mask(input logic [1:0] route);
    case (route)
      2'h0:    return 5'h00;
      2'h1:    return 5'h1E;
      2'h2:    return 5'h1C;
      default: return 5'h1F;
    endcase
  endfunction
endpackage

/* rtl/edge_if.sv */
`timescale 1ns/10ps
// link between the counter core and the external edge detector
interface edge_if;
  logic bypass;     // unsynchronised mode chosen
  logic arm_clear;  // forget a seen falling edge
  logic rise;       // one-cycle counted rising edge
  modport detector (input bypass, input arm_clear, output rise);
  modport user     (output bypass, output arm_clear, input rise);
endinterface

/* rtl/ext_edge_detect.sv */
`timescale 1ns/10ps
// finds counted rising edges of the external clock
module ext_edge_detect (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  input  wire logic   ext_clk_i,
  edge_if.detector    bus
);
  // all detector state
  typedef struct packed {
    logic s1;     // first sync stage
    logic s2;     // second sync stage
    logic s3;     // extra stage for synced mode
    logic prev;   // level seen last cycle
    logic armed;  // falling edge already seen
    logic rise;   // counted edge pulse
  } det_type;

  det_type q, d;
  logic    level;  // chosen sampled level

  // next state of the detector
  always_comb begin
    d       = q;
    d.s1    = ext_clk_i;
    d.s2    = q.s1;
    d.s3    = q.s2;
    level   = bus.bypass ? q.s2 : q.s3;
    d.prev  = level;
    d.rise  = level & ~q.prev & q.armed;
    if (bus.arm_clear) begin
      d.armed = 1'b0;
    end else if (!level && q.prev) begin
      d.armed = 1'b1;
    end
  end

  // register the detector
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.rise = q.rise;

  chk_edge_needs_arm: assert property (@(posedge clk_i) disable iff (reset_i)
    q.rise |-> $past(q.armed)) else $error("edge counted before a falling edge");
endmodule // ext_edge_detect

/* bench/ext_clock_source.sv */
`timescale 1ns/10ps
// behavioural external clock source, low between bursts
module ext_clock_source #(
  parameter int HALF_NS = 37  // half period, unrelated to the system clock
) (
  output logic ext_clk_o      // external clock level
);
  // idle level low outside bursts
  initial ext_clk_o = 1'b0;

  // whole pulses, rise then fall
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      #HALF_NS ext_clk_o = 1'b1;
      #HALF_NS ext_clk_o = 1'b0;
    end
  endtask
endmodule // ext_clock_source

/* bench/timer_counter_16bit_buffered_test.sv */
`timescale 1ns/10ps
// self-checking bench for the buffered 16-bit timer
module timer_counter_16bit_buffered_test;
  logic       clk_i   = 1'b0;   // system clock
  logic       reset_i = 1'b1;   // synchronous reset
  logic [3:0] addr_i  = 4'h0;   // register address
  logic [7:0] wdata_i = 8'h00;  // write data
  logic       wr_i    = 1'b0;   // write strobe
  logic       rd_i    = 1'b0;   // read strobe
  logic       osc_en  = 1'b0;   // oscillator enable
  logic [4:0] sev     = 5'h00;  // special-event pulses
  logic [1:0] dir     = 2'h3;   // pin directions
  logic [1:0] pout    = 2'h0;   // pin output values
  logic [1:0] pin     = 2'h0;   // raw pin levels
  logic [7:0] rdata_o;          // read data
  logic       ext_clk;          // partner clock
  logic [1:0] pin_out;          // pin output copy
  logic [1:0] pin_oe;           // pin enables
  logic [1:0] pin_rd;           // pin read value
  logic [4:0] route;            // unit routing
  logic       irq;              // interrupt line
  logic [7:0] d;                // last read value
  int         fail_count = 0;   // mismatches
  int         compares   = 0;   // comparisons
  int         cycles     = 0;   // timeout counter
  // expected routing per code
  const logic [4:0] route_exp [4] = '{5'h00, 5'h1E, 5'h1C, 5'h1F};

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // timeout guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // far-side clock model feeds both sources
  ext_clock_source src (.ext_clk_o(ext_clk));

  timer_counter_16bit_buffered uut (
    .clk_i                  (clk_i),
    .reset_i                (reset_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .ext_clock_pin_i        (ext_clk),
    .osc_clk_i              (ext_clk),
    .secondary_osc_enable_i (osc_en),
    .special_event_i        (sev),
    .compare_mode_field_i   (20'h0000B),
    .port_direction_i       (dir),
    .port_out_i             (pout),
    .pin_in_i               (pin),
    .pin_out_o              (pin_out),
    .pin_oe_o               (pin_oe),
    .pin_read_o             (pin_rd),
    .timebase_route_o       (route),
    .irq_o                  (irq)
  );

  // compare one value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // back-to-back writes, high byte then low byte
  task automatic wr_pair(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge clk_i);
    addr_i  <= 4'h2;
    wdata_i <= hi;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    addr_i  <= 4'h1;
    wdata_i <= lo;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // one-cycle register read, data sampled the cycle after
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask

  // reset state and unmapped address
  task automatic t_reset;
    rd(4'h0, d); chk(d, 8'h00);
    rd(4'h1, d); chk(d, 8'h00);
    rd(4'hF, d); chk(d, 8'h00);
    chk(8'(route), 8'h00);
  endtask

  // internal clock, all prescale codes, bypass bit ignored
  task automatic t_timer;
    for (int p = 0; p < 4; p++) begin
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h01 | 8'(p << 4) | (p[0] ? 8'h04 : 8'h00));
      repeat (32 << p) @(posedge clk_i);
      wr(4'h0, 8'h00);
      rd(4'h1, d);
      compares++;
      if ($isunknown(d) || d < 8'h07 || d > 8'h09) begin
        $display("Error at %0t: got %h expected %h", $time, d, 8'h08);
        fail_count++;
      end
    end
    repeat (40) @(posedge clk_i);
    rd(4'h1, d); chk(d, 8'h08);
  endtask

  // routing codes
  task automatic t_route;
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, {1'b0, c[1], 2'b00, c[0], 3'b000});
      repeat (2) @(posedge clk_i);
      chk(8'(route), 8'(route_exp[c]));
    end
    wr(4'h0, 8'h00);
  endtask

  // buffered wide access against live narrow access
  task automatic t_wide;
    wr(4'h2, 8'h20);
    wr(4'h1, 8'hFF);
    wr(4'h0, 8'h80);
    rd(4'h1, d); chk(d, 8'hFF);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h55);
    rd(4'h2, d); chk(d, 8'h55);
    wr(4'h0, 8'h80);
    rd(4'h2, d); chk(d, 8'h20);
    wr_pair(8'hAB, 8'hCD);
    wr(4'h2, 8'h77);
    wr(4'h0, 8'h00);
    rd(4'h2, d); chk(d, 8'hAB);
    rd(4'h1, d); chk(d, 8'hCD);
  endtask

  // wrap sets flag, enable gates interrupt line
  task automatic t_overflow;
    wr(4'h2, 8'hFF);
    wr(4'h1, 8'hFE);
    wr(4'h3, 8'h02);
    wr(4'h0, 8'h01);
    repeat (20) @(posedge clk_i);
    wr(4'h0, 8'h00);
    rd(4'h3, d); chk(d & 8'h03, 8'h03);
    rd(4'h2, d); chk(d, 8'h00);
    chk(8'(irq), 8'h01);
    wr(4'h3, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(8'(irq), 8'h00);
    wr(4'h3, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(8'(irq), 8'h00);
  endtask

  // special-event clear, precedence and routing gate
  task automatic t_special;
    wr(4'h0, 8'h79);
    wr(4'h1, 8'h80);
    @(posedge clk_i) sev <= 5'h01;
    @(posedge clk_i) sev <= 5'h00;
    rd(4'h1, d); chk(d, 8'h00);
    rd(4'h3, d); chk(d & 8'h01, 8'h00);
    @(posedge clk_i);
    addr_i  <= 4'h1;
    wdata_i <= 8'h40;
    wr_i    <= 1'b1;
    sev     <= 5'h01;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    sev     <= 5'h00;
    rd(4'h1, d); chk(d, 8'h40);
    wr(4'h0, 8'h31);
    wr(4'h1, 8'h80);
    @(posedge clk_i) sev <= 5'h01;
    @(posedge clk_i) sev <= 5'h00;
    rd(4'h1, d); chk(d, 8'h80);
    wr(4'h0, 8'h00);
  endtask

  // external edges, synced then unsynced, first rise not counted
  task automatic t_ext;
    for (int m = 0; m < 2; m++) begin
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
      @(posedge clk_i) osc_en <= m[0];
      wr(4'h0, m[0] ? 8'h07 : 8'h03);
      src.burst(5);
      repeat (10) @(posedge clk_i);
      wr(4'h0, 8'h00);
      rd(4'h1, d); chk(d, 8'h04);
    end
    @(posedge clk_i) osc_en <= 1'b0;
  endtask

  // oscillator pins forced to inputs and read as zero
  task automatic t_pins;
    @(posedge clk_i);
    dir  <= 2'h1;
    pout <= 2'h2;
    pin  <= 2'h3;
    repeat (4) @(posedge clk_i);
    chk(8'(pin_oe), 8'h02);
    chk(8'(pin_rd), 8'h03);
    chk(8'(pin_out), 8'h02);
    @(posedge clk_i) osc_en <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(8'(pin_oe), 8'h00);
    chk(8'(pin_rd), 8'h00);
  endtask

  // counts and verdict
  task automatic end_sim;
    $display("Counts: %0d mismatches in %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_timer();
    t_route();
    t_wide();
    t_overflow();
    t_special();
    t_ext();
    t_pins();
    end_sim();
  end
endmodule // timer_counter_16bit_buffered_test
